// >>> scsb_params.svh
// constants for the system clock select and boot block
`ifndef SCSB_PARAMS_SVH
`define SCSB_PARAMS_SVH
// timing
`define SCSB_CLK_MHZ 125
`define SCSB_NORMAL_BOOT_MS 55
`define SCSB_FAST_BOOT_US 850
`define SCSB_NORMAL_BOOT_CYC (`SCSB_NORMAL_BOOT_MS * 1000 * `SCSB_CLK_MHZ)
`define SCSB_FAST_BOOT_CYC (`SCSB_FAST_BOOT_US * `SCSB_CLK_MHZ)
`define SCSB_TRIM_TARGET_MHZ 16
// register byte offsets
`define SCSB_ADDR_CLKMD 4'h0
`define SCSB_ADDR_XTAL 4'h4
`define SCSB_ADDR_TRIM 4'h8
`define SCSB_ADDR_STATUS 4'hC
// clock mode codes
`define SCSB_CLKMD_DIV2 8'h34
`define SCSB_CLKMD_DIV4 8'h14
`define SCSB_CLKMD_DIV8 8'h3C
`define SCSB_CLKMD_DIV16 8'h1C
`define SCSB_CLKMD_DIV32 8'h7C
`define SCSB_CLKMD_SLOW 8'hE4
`define SCSB_CLKMD_XTAL 8'hB4
`define SCSB_CLKMD_RST 8'hE4
// field positions
`define SCSB_FAST_EN_BIT 4
`define SCSB_SLOW_EN_BIT 2
`define SCSB_XTAL_EN_BIT 7
// reset and calibration values
`define SCSB_XTAL_RST 8'h00
`define SCSB_TRIM_RST 8'h00
`define SCSB_CAL_TRIM 8'h80
// divider half periods in source edges
`define SCSB_HALF_FAST64 7'h40
`define SCSB_HALF_ONE 7'h01
// bus responses
`define SCSB_RESP_OKAY 2'b00
`define SCSB_RESP_SLVERR 2'b10
`endif

// >>> scsb_pkg.sv
// types for the system clock select and boot block
package scsb_pkg;
  typedef enum logic [2:0] {
    OPT_DIV2 = 3'd0,
    OPT_DIV4 = 3'd1,
    OPT_DIV8 = 3'd2,
    OPT_DIV16 = 3'd3,
    OPT_DIV32 = 3'd4,
    OPT_SLOW = 3'd5,
    OPT_DISABLE = 3'd6
  } scsb_opt_t;
  typedef enum logic [1:0] {
    SRC_FAST = 2'd0,
    SRC_SLOW = 2'd1,
    SRC_XTAL = 2'd2
  } scsb_src_t;
  typedef enum logic [1:0] {
    BT_SYNC = 2'b00,
    BT_WAIT = 2'b01,
    BT_RUN = 2'b11
  } scsb_boot_t;
endpackage

// >>> scsb_clk_ctrl.sv
// system clock source selection, oscillator enables, trim and power-on boot
`timescale 1ns/10ps
`include "scsb_params.svh"

module scsb_clk_ctrl #(
  parameter int unsigned NORMAL_BOOT_CYC = `SCSB_NORMAL_BOOT_CYC,
  parameter int unsigned FAST_BOOT_CYC = `SCSB_FAST_BOOT_CYC,
  parameter logic [7:0] CAL_TRIM = `SCSB_CAL_TRIM
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_trim_opt,
  input wire logic i_fast_boot,
  input wire logic i_fast_rc_osc,
  input wire logic i_slow_rc_osc,
  input wire logic i_crystal_osc,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [3:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [3:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_crystal_osc_en,
  output logic o_fast_rc_osc_en,
  output logic o_slow_rc_osc_en,
  output logic [7:0] o_fast_rc_trim,
  output logic o_wdt_en,
  output logic o_port_a_bit5_in,
  output logic o_boot_done,
  output logic o_sys_clk
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] osc_s1_q, osc_s2_q, osc_s3_q;
  logic [3:0] strap_s1_q, strap_s2_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_s1_q <= 3'h0;
      osc_s2_q <= 3'h0;
      osc_s3_q <= 3'h0;
      strap_s1_q <= 4'h0;
      strap_s2_q <= 4'h0;
    end else begin
      osc_s1_q <= {i_crystal_osc, i_slow_rc_osc, i_fast_rc_osc};
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      strap_s1_q <= {i_fast_boot, i_trim_opt};
      strap_s2_q <= strap_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot sequencer
  scsb_pkg::scsb_boot_t boot_q;
  scsb_pkg::scsb_opt_t opt_q;
  logic fast_q;
  logic [23:0] boot_cnt_q;
  logic [23:0] boot_last;
  logic boot_apply;

  assign boot_last = fast_q ? 24'(FAST_BOOT_CYC - 1) : 24'(NORMAL_BOOT_CYC - 1);
  assign boot_apply = (boot_q == scsb_pkg::BT_WAIT) && (boot_cnt_q == boot_last);

  // straps caught after reset release once the synchronisers have filled
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_q <= scsb_pkg::BT_SYNC;
      opt_q <= scsb_pkg::OPT_DISABLE;
      fast_q <= 1'b0;
      boot_cnt_q <= 24'h00_0000;
    end else begin
      unique case (boot_q)
        scsb_pkg::BT_SYNC: begin
          boot_cnt_q <= boot_cnt_q + 24'h00_0001;
          if (boot_cnt_q == 24'h00_0002) begin
            opt_q <= scsb_pkg::scsb_opt_t'(strap_s2_q[2:0]);
            fast_q <= strap_s2_q[3];
            boot_cnt_q <= 24'h00_0000;
            boot_q <= scsb_pkg::BT_WAIT;
          end
        end
        scsb_pkg::BT_WAIT: begin
          boot_cnt_q <= boot_cnt_q + 24'h00_0001;
          if (boot_apply) begin
            boot_q <= scsb_pkg::BT_RUN;
          end
        end
        scsb_pkg::BT_RUN: boot_cnt_q <= boot_cnt_q;
        default: boot_q <= scsb_pkg::BT_SYNC;
      endcase
    end
  end

  function automatic logic [7:0] opt_code(input scsb_pkg::scsb_opt_t opt);
    unique case (opt)
      scsb_pkg::OPT_DIV2: opt_code = `SCSB_CLKMD_DIV2;
      scsb_pkg::OPT_DIV4: opt_code = `SCSB_CLKMD_DIV4;
      scsb_pkg::OPT_DIV8: opt_code = `SCSB_CLKMD_DIV8;
      scsb_pkg::OPT_DIV16: opt_code = `SCSB_CLKMD_DIV16;
      scsb_pkg::OPT_DIV32: opt_code = `SCSB_CLKMD_DIV32;
      default: opt_code = `SCSB_CLKMD_SLOW;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus slave
  logic aw_hold_q, w_hold_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic lane0_q;
  logic wr_en, wr_ok;
  logic [7:0] clkmd_q, xtal_q, trim_q;
  logic [31:0] status_w;
  scsb_pkg::scsb_src_t cur_src_q;

  assign wr_en = aw_hold_q && w_hold_q && !o_bvalid;
  // writes during boot are refused so the boot values cannot be overtaken
  assign wr_ok = wr_en && o_boot_done && lane0_q && (awaddr_q != `SCSB_ADDR_STATUS);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      lane0_q <= 1'b0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `SCSB_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= i_wdata;
        lane0_q <= i_wstrb[0];
        o_wready <= 1'b0;
      end
      if (wr_en) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (o_boot_done && awaddr_q[1:0] == 2'b00 && awaddr_q != `SCSB_ADDR_STATUS) ?
                   `SCSB_RESP_OKAY : `SCSB_RESP_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  assign status_w = {24'h00_0000, o_boot_done, o_wdt_en, fast_q, opt_q, cur_src_q};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `SCSB_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= `SCSB_RESP_OKAY;
      unique case (i_araddr)
        `SCSB_ADDR_CLKMD: o_rdata <= {24'h00_0000, clkmd_q};
        `SCSB_ADDR_XTAL: o_rdata <= {24'h00_0000, xtal_q};
        `SCSB_ADDR_TRIM: o_rdata <= {24'h00_0000, trim_q};
        `SCSB_ADDR_STATUS: o_rdata <= status_w;
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= `SCSB_RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clkmd_q <= `SCSB_CLKMD_RST;
    end else if (boot_apply && opt_q != scsb_pkg::OPT_DISABLE) begin
      clkmd_q <= opt_code(opt_q);
    end else if (wr_ok && awaddr_q == `SCSB_ADDR_CLKMD) begin
      clkmd_q <= wdata_q[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xtal_q <= `SCSB_XTAL_RST;
    end else if (wr_ok && awaddr_q == `SCSB_ADDR_XTAL) begin
      xtal_q <= wdata_q[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trim_q <= `SCSB_TRIM_RST;
    end else if (boot_apply && opt_q != scsb_pkg::OPT_DISABLE) begin
      trim_q <= CAL_TRIM;
    end else if (wr_ok && awaddr_q == `SCSB_ADDR_TRIM) begin
      trim_q <= wdata_q[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wdt_en <= 1'b0;
      o_boot_done <= 1'b0;
      o_port_a_bit5_in <= 1'b1;
    end else begin
      o_port_a_bit5_in <= 1'b1;
      if (boot_apply) begin
        o_wdt_en <= (opt_q == scsb_pkg::OPT_DISABLE);
        o_boot_done <= 1'b1;
      end
    end
  end

  // enables are the register bits themselves
  assign o_fast_rc_osc_en = clkmd_q[`SCSB_FAST_EN_BIT];
  assign o_slow_rc_osc_en = clkmd_q[`SCSB_SLOW_EN_BIT];
  assign o_crystal_osc_en = xtal_q[`SCSB_XTAL_EN_BIT];
  assign o_fast_rc_trim = trim_q;

  ////////////////////////////////////////////////////////////////////////////
  // clock selection and divider
  scsb_pkg::scsb_src_t want_src;
  logic [6:0] want_half, cur_half_q, div_cnt_q;
  logic src_edge;

  // unknown codes fall back to fast rc /64
  always_comb begin
    want_src = scsb_pkg::SRC_FAST;
    want_half = `SCSB_HALF_FAST64;
    unique case (clkmd_q)
      `SCSB_CLKMD_DIV2: want_half = 7'h02;
      `SCSB_CLKMD_DIV4: want_half = 7'h04;
      `SCSB_CLKMD_DIV8: want_half = 7'h08;
      `SCSB_CLKMD_DIV16: want_half = 7'h10;
      `SCSB_CLKMD_DIV32: want_half = 7'h20;
      `SCSB_CLKMD_SLOW: begin
        want_src = scsb_pkg::SRC_SLOW;
        want_half = `SCSB_HALF_ONE;
      end
      `SCSB_CLKMD_XTAL: begin
        want_src = scsb_pkg::SRC_XTAL;
        want_half = `SCSB_HALF_ONE;
      end
      default: want_half = `SCSB_HALF_FAST64;
    endcase
  end

  assign src_edge = osc_s2_q[cur_src_q] ^ osc_s3_q[cur_src_q];

  // switch only at the start of a low phase so no pulse is cut short;
  // a disabled target source stalls the clock low until it runs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_src_q <= scsb_pkg::SRC_SLOW;
      cur_half_q <= `SCSB_HALF_ONE;
      div_cnt_q <= 7'h00;
      o_sys_clk <= 1'b0;
    end else if ((cur_src_q != want_src || cur_half_q != want_half) && !o_sys_clk
                 && div_cnt_q == 7'h00) begin
      cur_src_q <= want_src;
      cur_half_q <= want_half;
    end else if (src_edge) begin
      if (div_cnt_q == cur_half_q - 7'h01) begin
        div_cnt_q <= 7'h00;
        o_sys_clk <= !o_sys_clk;
      end else begin
        div_cnt_q <= div_cnt_q + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic [23:0] chk_boot_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chk_boot_q <= 24'h00_0000;
    end else if (boot_q == scsb_pkg::BT_WAIT) begin
      chk_boot_q <= chk_boot_q + 24'h00_0001;
    end
  end

  sequence clkmd_write_s;
    wr_ok && awaddr_q == `SCSB_ADDR_CLKMD;
  endsequence
  sequence boot_end_s;
    $rose(o_boot_done);
  endsequence

  osc_enable_a: assert property (clkmd_write_s |=> o_fast_rc_osc_en == $past(wdata_q[4])
    && o_slow_rc_osc_en == $past(wdata_q[2])) else $error("enable bits not following write");
  boot_rc_on_a: assert property (boot_end_s and (opt_q <= scsb_pkg::OPT_DIV32) |->
    o_fast_rc_osc_en && o_slow_rc_osc_en) else $error("rc oscillators not running after boot");
  trim_write_a: assert property (wr_ok && awaddr_q == `SCSB_ADDR_TRIM |=>
    o_fast_rc_trim == $past(wdata_q[7:0])) else $error("trim write lost");
  decode_div_a: assert property (clkmd_q == `SCSB_CLKMD_DIV8 |-> want_half == 7'h08
    && want_src == scsb_pkg::SRC_FAST) else $error("divide by 8 decode wrong");
  decode_slow_a: assert property (clkmd_q == `SCSB_CLKMD_SLOW |->
    want_src == scsb_pkg::SRC_SLOW && want_half == 7'h01) else $error("slow rc decode wrong");
  boot_slow_a: assert property (boot_end_s and opt_q == scsb_pkg::OPT_SLOW |->
    clkmd_q == 8'hE4 && !o_fast_rc_osc_en) else $error("slow option boot state wrong");
  boot_cal_a: assert property (boot_end_s and opt_q != scsb_pkg::OPT_DISABLE |->
    !o_wdt_en && o_slow_rc_osc_en && o_port_a_bit5_in && o_fast_rc_trim == CAL_TRIM)
    else $error("calibrated boot state wrong");
  boot_nocal_a: assert property (boot_end_s and opt_q == scsb_pkg::OPT_DISABLE |->
    o_wdt_en && clkmd_q == `SCSB_CLKMD_RST && o_fast_rc_trim == `SCSB_TRIM_RST && !o_fast_rc_osc_en)
    else $error("uncalibrated boot state wrong");
  boot_time_a: assert property (boot_end_s |-> chk_boot_q == boot_last + 24'h00_0001)
    else $error("boot period length wrong");
  boot_code_a: assert property (boot_end_s and opt_q == scsb_pkg::OPT_DIV4 |->
    clkmd_q == 8'h14 && o_fast_rc_osc_en) else $error("divider code after boot wrong");
  mode_now_a: assert property (clkmd_write_s |=> clkmd_q == $past(wdata_q[7:0]))
    else $error("mode write not applied");
  switch_now_a: assert property ((cur_src_q != want_src || cur_half_q != want_half) && !o_sys_clk
    && div_cnt_q == 7'h00 |=> cur_src_q == $past(want_src) && cur_half_q == $past(want_half))
    else $error("source switch delayed");
  glitch_free_a: assert property ($changed(cur_src_q) || $changed(cur_half_q) |->
    !o_sys_clk && $past(div_cnt_q) == 7'h00) else $error("source switched mid pulse");

endmodule // scsb_clk_ctrl

// >>> system_clock_select_boot_tb.sv
// self-checking testbench for the system clock select and boot block
`timescale 1ns/10ps
module system_clock_select_boot_tb;
  localparam int NB = 40;
  localparam int FB = 10;
  localparam logic [7:0] CAL = 8'h5A;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] opt_s = 3'd0;
  logic fboot = 1'b0;
  logic fosc = 1'b0;
  logic sosc = 1'b0;
  logic xosc = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] rr_last = 2'b00;
  logic awready, wready, bvalid, arready, rvalid, xen, fen, sen, wdt, pa5, bdone, sys_clk;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] trim;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;

  scsb_clk_ctrl #(.NORMAL_BOOT_CYC(NB), .FAST_BOOT_CYC(FB), .CAL_TRIM(CAL)) scsb_clk_ctrl_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_trim_opt(opt_s), .i_fast_boot(fboot),
    .i_fast_rc_osc(fosc), .i_slow_rc_osc(sosc), .i_crystal_osc(xosc),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp), .o_crystal_osc_en(xen), .o_fast_rc_osc_en(fen),
    .o_slow_rc_osc_en(sen), .o_fast_rc_trim(trim), .o_wdt_en(wdt), .o_port_a_bit5_in(pa5),
    .o_boot_done(bdone), .o_sys_clk(sys_clk)
  );

  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // oscillators locked to clk so sys_clk periods come out in whole cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 5 == 4) fosc <= ~fosc;
    if (cyc % 13 == 12) sosc <= ~sosc;
    if (cyc % 7 == 6) xosc <= ~xosc;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    r = 2'b11;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    bready <= 1'b1;
    while (!done && n < 200) begin
      @(posedge clk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) chk(0, 1, "write hang");
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    d = 32'hFFFF_FFFF;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!done && n < 200) begin
      @(posedge clk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        rr_last = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) chk(0, 1, "read hang");
  endtask

  // period of sys_clk in clk cycles, last of three rising edges
  task automatic per(output int p);
    int n, t0, k;
    logic last;
    n = 0;
    t0 = 0;
    k = 0;
    p = 0;
    last = sys_clk;
    while (k < 3 && n < 3000) begin
      @(posedge clk);
      n++;
      if (sys_clk === 1'b1 && last === 1'b0) begin
        k++;
        p = n - t0;
        t0 = n;
      end
      last = sys_clk;
    end
  endtask

  function automatic logic [7:0] md(input logic [2:0] o);
    case (o)
      3'd0: md = 8'h34;
      3'd1: md = 8'h14;
      3'd2: md = 8'h3C;
      3'd3: md = 8'h1C;
      3'd4: md = 8'h7C;
      default: md = 8'hE4;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // power-on with a strap set; early write must be refused while booting
  task automatic boot(input logic [2:0] o, input logic fast, input logic early);
    int n;
    logic [1:0] r;
    @(posedge clk);
    rst_n <= 1'b0;
    opt_s <= o;
    fboot <= fast;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    if (early) begin
      axi_wr(4'h0, 8'h1C, r);
      chk(r, 2'b10, "write during boot");
    end
    n = 0;
    while (bdone !== 1'b1 && n < 2 * NB) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (!early) chk(n, (fast ? FB : NB) + 3, "boot length");
  endtask

  task automatic chk_boot(input logic [2:0] o);
    logic [31:0] d;
    int p;
    axi_rd(4'h0, d);
    chk(d, {24'h00_0000, md(o)}, "clock mode after boot");
    chk(rr_last, 2'b00, "clock mode read response");
    chk(fen, o < 3'd5, "fast rc enable");
    chk(sen, 1'b1, "slow rc enable");
    chk(wdt, o == 3'd6, "watchdog");
    chk(pa5, 1'b1, "port a bit5 input");
    chk(trim, (o == 3'd6) ? 8'h00 : CAL, "trim after boot");
    chk(xen, 1'b0, "crystal off");
    per(p);
    chk(p, (o < 3'd5) ? 10 * (2 << o) : 26, "sys clk period");
  endtask

  // enable crystal first, then select it; trim and status access
  task automatic sw_test();
    logic [1:0] r;
    logic [31:0] d;
    int p;
    axi_wr(4'h4, 8'h80, r);
    chk({xen, fen, sen}, 3'b111, "crystal enable alone");
    axi_wr(4'h0, 8'hB4, r);
    chk(r, 2'b00, "select crystal");
    per(p);
    chk(p, 14, "crystal period");
    // status read only once the switch has surely happened
    axi_rd(4'hC, d);
    chk(d, 32'h0000_00A2, "status on crystal");
    axi_wr(4'h0, 8'h14, r);
    per(p);
    chk(p, 40, "back to fast div4");
    axi_wr(4'h0, 8'h54, r);
    per(p);
    chk(p, 640, "unlisted code fast rc /64");
    axi_wr(4'h4, 8'h00, r);
    chk({xen, fen, sen}, 3'b011, "crystal disable alone");
    axi_wr(4'h8, 8'hC3, r);
    chk(trim, 8'hC3, "trim write");
    axi_rd(4'h8, d);
    chk(d, 32'h0000_00C3, "trim read");
    wstrb <= 4'h0;
    axi_wr(4'h8, 8'h3C, r);
    wstrb <= 4'hF;
    chk(r, 2'b00, "no lane write okay");
    chk(trim, 8'hC3, "no lane write ignored");
    axi_rd(4'h2, d);
    chk(d, 32'h0000_0000, "unmapped read data");
    chk(rr_last, 2'b10, "unmapped read refused");
    axi_wr(4'hC, 8'h00, r);
    chk(r, 2'b10, "status write refused");
  endtask

  initial begin
    for (int o = 0; o < 7; o++) begin
      boot(o[2:0], o[0], 1'b0);
      chk_boot(o[2:0]);
    end
    boot(3'd1, 1'b0, 1'b1);
    chk_boot(3'd1);
    boot(3'd0, 1'b1, 1'b0);
    sw_test();
    stop_test();
  end
endmodule // system_clock_select_boot_tb
